// ---- verilog/cms_ctrl.sv ----
/*
 * command-mode entry/exit and sleep scheduling of a serial wireless module.
 * holds queued and active settings, reached through decoded commands.
 * assumes host characters arrive as same-clock strobes from the serial
 * receiver, and the command parser hands decoded commands in command mode.
 */
//
// Contract
// - command mode ends after idle timeout, 100 ms steps, 2..0x1770, reset 0x64.
// - pending settings are applied whenever command mode ends.
// - guard silence before and after escapes, 1 ms steps, max 0xce4, reset 0x3e8.
// - entry only on silence, three escape characters, silence; escape resets 0x2b.
// - sleep mode codes 0 none, 1 pin, 4 cyclic, 5 cyclic with pin wake.
// - option bit 0x40 keeps the association while asleep.
// - sleep lasts the sleep period in 10 ms units, 1..0x83d600, reset 0xc8.
// - option bit 0x100 set; new receptions never restart the wake timer.
// - nonzero host-wake delay holds serial output that many ms after wake.
// - any received host character stops the host-wake delay at once.
// - cyclic modes stay awake for the wake window, 1 ms units, not refreshed.
// - pending transmit or receive work finishes before sleep is entered; pin mode goes straight to the join wait without that drain.
// - wait up to the join limit for association before deep sleep.
// - a read-only two-byte code identifies the active configuration.
// - link margin reads back as 0..0xff in dB above sensitivity.
// - supply voltage reads back in millivolts.
// - writes are queued and take effect only on an apply event.
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_ctrl
    import cms_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `CMS_MS_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    output logic             data_valid,
    output logic [7:0]       data_byte,
    input  wire logic        cmd_valid,
    input  wire cms_cmd_s    cmd,
    output logic             rsp_valid,
    output cms_rsp_s         rsp,
    output logic             command_mode,
    output logic             apply_strobe,
    input  wire logic        sleep_rq_pin,
    input  wire logic        associated,
    input  wire logic        work_pending,
    input  wire logic [15:0] supply_mv_in,
    input  wire logic [7:0]  link_margin_in,
    output logic             asleep,
    output logic             keep_association,
    output logic             serial_hold
);

    typedef enum logic [4:0] {
        ESC_SILENCE = 5'b00001,
        ESC_ARMED   = 5'b00010,
        ESC_ONE     = 5'b00100,
        ESC_TWO     = 5'b01000,
        ESC_THREE   = 5'b10000
    } cms_esc_e;

    typedef enum logic [4:0] {
        SLP_RUN   = 5'b00001,
        SLP_WAKE  = 5'b00010,
        SLP_DRAIN = 5'b00100,
        SLP_JOIN  = 5'b01000,
        SLP_SLEEP = 5'b10000
    } cms_slp_e;

    // legal-value check for a write; bit 0x100 of the options is mandatory
    function automatic logic cms_legal(input logic [3:0] idx, input logic [31:0] v);
        unique case (idx)
            `CMS_IDX_IDLE_TIMEOUT:
                cms_legal = v >= `CMS_MIN_IDLE_TIMEOUT && v <= `CMS_MAX_IDLE_TIMEOUT;
            `CMS_IDX_GUARD_TIME:
                cms_legal = v >= `CMS_MIN_GUARD_TIME && v <= `CMS_MAX_GUARD_TIME;
            `CMS_IDX_ESCAPE_CHAR:
                cms_legal = v <= `CMS_MAX_ESCAPE_CHAR;
            `CMS_IDX_SLEEP_MODE:
                cms_legal = v[31:8] == 24'h0 && (v[7:0] == `CMS_MODE_NONE
                            || v[7:0] == `CMS_MODE_PIN || v[7:0] == `CMS_MODE_CYCLIC
                            || v[7:0] == `CMS_MODE_CYCLIC_PIN);
            `CMS_IDX_SLEEP_DUR:
                cms_legal = v >= `CMS_MIN_SLEEP_DUR && v <= `CMS_MAX_SLEEP_DUR;
            `CMS_IDX_SLEEP_OPT:
                cms_legal = v <= `CMS_MAX_SLEEP_OPT && v[`CMS_OPT_NO_RESTART];
            `CMS_IDX_WAKE_DELAY:
                cms_legal = v <= `CMS_MAX_WAKE_DELAY;
            `CMS_IDX_AWAKE_WIN, `CMS_IDX_JOIN_WAIT:
                cms_legal = v >= `CMS_MIN_AWAKE_WIN && v <= `CMS_MAX_AWAKE_WIN;
            default:
                cms_legal = 1'b0;
        endcase
    endfunction : cms_legal

    localparam cms_cfg_s CFG_RESET = '{
        idle_timeout: `CMS_RST_IDLE_TIMEOUT,
        guard_time:   `CMS_RST_GUARD_TIME,
        escape_char:  `CMS_RST_ESCAPE_CHAR,
        sleep_mode:   `CMS_RST_SLEEP_MODE,
        sleep_dur:    `CMS_RST_SLEEP_DUR,
        sleep_opt:    `CMS_RST_SLEEP_OPT,
        wake_delay:   `CMS_RST_WAKE_DELAY,
        awake_win:    `CMS_RST_AWAKE_WIN,
        join_wait:    `CMS_RST_JOIN_WAIT
    };

    logic        tick;
    cms_cfg_s    pending;
    cms_cfg_s    active;
    cms_esc_e    esc_state;
    cms_esc_e    next_esc_state;
    cms_slp_e    slp_state;
    cms_slp_e    next_slp_state;
    logic [15:0] silence_ms;
    logic [19:0] idle_ms;
    logic [31:0] phase_ms;
    logic [15:0] hold_ms;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
    logic        pin_sleep;
    logic        pin_sleep_q;
    logic        cmd_take;
    logic        idle_expired;
    logic        leave_now;
    logic        apply_now;
    logic        enter_cmd;
    logic        cyclic;
    logic [15:0] config_code;

    cms_ms_tick #(
        .CYCLES (MS_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tick    (tick)
    );

    // pin sleep request: three stages, level taken once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_s3    <= 1'b0;
            pin_sleep <= 1'b0;
        end else begin
            pin_s1 <= sleep_rq_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_sleep <= pin_s3;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        pin_sleep_q <= reset ? 1'b0 : pin_sleep;
    end

    // escape sequence detection
    always_ff @(posedge ref_clk) begin
        if (reset || rx_valid) begin
            silence_ms <= 16'h0;
        end else if (tick && silence_ms != 16'hffff) begin
            silence_ms <= silence_ms + 16'h1;
        end
    end

    always_comb begin
        next_esc_state = esc_state;
        enter_cmd      = 1'b0;
        if (command_mode) begin
            next_esc_state = ESC_SILENCE;
        end else begin
            unique case (esc_state)
                ESC_SILENCE: begin
                    if (!rx_valid && silence_ms >= active.guard_time) begin
                        next_esc_state = ESC_ARMED;
                    end
                end
                ESC_ARMED: begin
                    if (rx_valid) begin
                        next_esc_state = (rx_byte == active.escape_char) ? ESC_ONE
                                                                         : ESC_SILENCE;
                    end
                end
                ESC_ONE, ESC_TWO: begin
                    if (rx_valid) begin
                        if (rx_byte != active.escape_char) begin
                            next_esc_state = ESC_SILENCE;
                        end else begin
                            next_esc_state = (esc_state == ESC_ONE) ? ESC_TWO : ESC_THREE;
                        end
                    end
                end
                ESC_THREE: begin
                    if (rx_valid) begin
                        next_esc_state = ESC_SILENCE;
                    end else if (silence_ms >= active.guard_time) begin
                        next_esc_state = ESC_SILENCE;
                        enter_cmd      = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        esc_state <= reset ? ESC_SILENCE : next_esc_state;
    end

    // characters outside command mode pass on as data, escapes included
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_valid <= 1'b0;
            data_byte  <= 8'h0;
        end else begin
            data_valid <= rx_valid && !command_mode;
            if (rx_valid) begin
                data_byte <= rx_byte;
            end
        end
    end

    // command mode, idle timeout and apply events
    assign cmd_take     = cmd_valid && command_mode;
    assign idle_expired = idle_ms >= 20'(active.idle_timeout * `CMS_IDLE_STEP_MS);
    assign leave_now    = command_mode && (idle_expired
                          || (cmd_take && cmd.op == CMS_OP_LEAVE));
    assign apply_now    = leave_now || (cmd_take && cmd.op == CMS_OP_APPLY);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            command_mode <= 1'b0;
        end else if (leave_now) begin
            command_mode <= 1'b0;
        end else if (enter_cmd) begin
            command_mode <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !command_mode || cmd_take) begin
            idle_ms <= 20'h0;
        end else if (tick) begin
            idle_ms <= idle_ms + 20'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        apply_strobe <= !reset && apply_now;
    end

    // queued and active settings
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pending <= CFG_RESET;
        end else if (cmd_take && cmd.op == CMS_OP_WRITE && cms_legal(cmd.idx, cmd.data)) begin
            unique case (cmd.idx)
                `CMS_IDX_IDLE_TIMEOUT: pending.idle_timeout <= cmd.data[15:0];
                `CMS_IDX_GUARD_TIME:   pending.guard_time   <= cmd.data[15:0];
                `CMS_IDX_ESCAPE_CHAR:  pending.escape_char  <= cmd.data[7:0];
                `CMS_IDX_SLEEP_MODE:   pending.sleep_mode   <= cmd.data[7:0];
                `CMS_IDX_SLEEP_DUR:    pending.sleep_dur    <= cmd.data[23:0];
                `CMS_IDX_SLEEP_OPT:    pending.sleep_opt    <= cmd.data[15:0];
                `CMS_IDX_WAKE_DELAY:   pending.wake_delay   <= cmd.data[15:0];
                `CMS_IDX_AWAKE_WIN:    pending.awake_win    <= cmd.data[23:0];
                default:               pending.join_wait    <= cmd.data[23:0];
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            active <= CFG_RESET;
        end else if (apply_now) begin
            active <= pending;
        end
    end

    // fold of the active settings; an applied setting change can leave it unchanged
    assign config_code = active.idle_timeout ^ active.guard_time
                       ^ {active.sleep_mode, active.escape_char}
                       ^ active.sleep_dur[23:8] ^ {active.sleep_dur[7:0], 8'h0}
                       ^ active.sleep_opt ^ active.wake_delay
                       ^ active.awake_win[23:8] ^ {active.awake_win[7:0], 8'h0}
                       ^ active.join_wait[23:8] ^ {active.join_wait[7:0], 8'h0};

    // responses: reads show active values, illegal writes answer not ok
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end else begin
            rsp_valid <= cmd_take;
            if (cmd_take) begin
                rsp.ok   <= 1'b1;
                rsp.data <= 32'h0;
                if (cmd.op == CMS_OP_WRITE) begin
                    rsp.ok <= cms_legal(cmd.idx, cmd.data);
                end else if (cmd.op == CMS_OP_READ) begin
                    unique case (cmd.idx)
                        `CMS_IDX_CONFIG_CODE:  rsp.data <= {16'h0, config_code};
                        `CMS_IDX_SUPPLY_MV:    rsp.data <= {16'h0, supply_mv_in};
                        `CMS_IDX_LINK_MARGIN:  rsp.data <= {24'h0, link_margin_in};
                        `CMS_IDX_IDLE_TIMEOUT: rsp.data <= {16'h0, active.idle_timeout};
                        `CMS_IDX_GUARD_TIME:   rsp.data <= {16'h0, active.guard_time};
                        `CMS_IDX_ESCAPE_CHAR:  rsp.data <= {24'h0, active.escape_char};
                        `CMS_IDX_SLEEP_MODE:   rsp.data <= {24'h0, active.sleep_mode};
                        `CMS_IDX_SLEEP_DUR:    rsp.data <= {8'h0, active.sleep_dur};
                        `CMS_IDX_SLEEP_OPT:    rsp.data <= {16'h0, active.sleep_opt};
                        `CMS_IDX_WAKE_DELAY:   rsp.data <= {16'h0, active.wake_delay};
                        `CMS_IDX_AWAKE_WIN:    rsp.data <= {8'h0, active.awake_win};
                        `CMS_IDX_JOIN_WAIT:    rsp.data <= {8'h0, active.join_wait};
                        default:               rsp.ok   <= 1'b0;
                    endcase
                end
            end
        end
    end

    // sleep scheduling; phase_ms restarts only on a state change, never on data
    assign cyclic = active.sleep_mode == `CMS_MODE_CYCLIC
                 || active.sleep_mode == `CMS_MODE_CYCLIC_PIN;

    always_comb begin
        next_slp_state = slp_state;
        unique case (slp_state)
            SLP_RUN: begin
                if (cyclic) begin
                    next_slp_state = SLP_WAKE;
                end else if (active.sleep_mode == `CMS_MODE_PIN && pin_sleep) begin
                    next_slp_state = SLP_JOIN;
                end
            end
            SLP_WAKE: begin
                if (!cyclic) begin
                    next_slp_state = SLP_RUN;
                end else if (phase_ms >= {8'h0, active.awake_win}) begin
                    next_slp_state = work_pending ? SLP_DRAIN : SLP_JOIN;
                end
            end
            SLP_DRAIN: begin
                if (!work_pending) begin
                    next_slp_state = SLP_JOIN;
                end
            end
            SLP_JOIN: begin
                if (associated || phase_ms >= {8'h0, active.join_wait}) begin
                    next_slp_state = SLP_SLEEP;
                end
            end
            SLP_SLEEP: begin
                if (active.sleep_mode == `CMS_MODE_NONE) begin
                    next_slp_state = SLP_RUN;
                end else if (active.sleep_mode == `CMS_MODE_PIN) begin
                    next_slp_state = pin_sleep ? SLP_SLEEP : SLP_RUN;
                end else if (phase_ms >= 32'(active.sleep_dur * `CMS_SLEEP_STEP_MS)
                             || (active.sleep_mode == `CMS_MODE_CYCLIC_PIN
                                 && pin_sleep_q && !pin_sleep)) begin
                    next_slp_state = SLP_WAKE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        slp_state <= reset ? SLP_RUN : next_slp_state;
    end

    always_ff @(posedge ref_clk) begin
        if (reset || next_slp_state != slp_state) begin
            phase_ms <= 32'h0;
        end else if (tick && phase_ms != 32'hffff_ffff) begin
            phase_ms <= phase_ms + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            asleep           <= 1'b0;
            keep_association <= 1'b0;
        end else begin
            asleep           <= next_slp_state == SLP_SLEEP;
            keep_association <= next_slp_state == SLP_SLEEP
                                && active.sleep_opt[`CMS_OPT_KEEP_ASSOC];
        end
    end

    // host-wake delay after leaving sleep
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            serial_hold <= 1'b0;
            hold_ms     <= 16'h0;
        end else if (slp_state == SLP_SLEEP && next_slp_state != SLP_SLEEP) begin
            serial_hold <= active.wake_delay != 16'h0 && !rx_valid;
            hold_ms     <= 16'h0;
        end else if (rx_valid) begin
            serial_hold <= 1'b0;
        end else if (serial_hold && tick) begin
            hold_ms <= hold_ms + 16'h1;
            if (hold_ms + 16'h1 >= active.wake_delay) begin
                serial_hold <= 1'b0;
            end
        end
    end

endmodule : cms_ctrl

// ---- verilog/cms_params.svh ----
/*
 * constants for the command-mode and sleep controller: command indices,
 * reset values, legal ranges and time bases.
 * assumes a 200 MHz ref_clk; included by bare name from package and modules.
 */
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// command indices of the settings and read-only values
`define CMS_IDX_CONFIG_CODE   4'h0
`define CMS_IDX_SUPPLY_MV     4'h1
`define CMS_IDX_LINK_MARGIN   4'h2
`define CMS_IDX_IDLE_TIMEOUT  4'h3
`define CMS_IDX_GUARD_TIME    4'h4
`define CMS_IDX_ESCAPE_CHAR   4'h5
`define CMS_IDX_SLEEP_MODE    4'h6
`define CMS_IDX_SLEEP_DUR     4'h7
`define CMS_IDX_SLEEP_OPT     4'h8
`define CMS_IDX_WAKE_DELAY    4'h9
`define CMS_IDX_AWAKE_WIN     4'ha
`define CMS_IDX_JOIN_WAIT     4'hb

// reset values
`define CMS_RST_IDLE_TIMEOUT  16'h0064
`define CMS_RST_GUARD_TIME    16'h03e8
`define CMS_RST_ESCAPE_CHAR   8'h2b
`define CMS_RST_SLEEP_MODE    8'h00
`define CMS_RST_SLEEP_DUR     24'h0000c8
`define CMS_RST_SLEEP_OPT     16'h0100
`define CMS_RST_WAKE_DELAY    16'h0000
`define CMS_RST_AWAKE_WIN     24'h0007d0
`define CMS_RST_JOIN_WAIT     24'h002710

// legal ranges
`define CMS_MIN_IDLE_TIMEOUT  32'h0000_0002
`define CMS_MAX_IDLE_TIMEOUT  32'h0000_1770
`define CMS_MIN_GUARD_TIME    32'h0000_0002
`define CMS_MAX_GUARD_TIME    32'h0000_0ce4
`define CMS_MIN_SLEEP_DUR     32'h0000_0001
`define CMS_MAX_SLEEP_DUR     32'h0083_d600
`define CMS_MAX_SLEEP_OPT     32'h0000_01ff
`define CMS_MAX_WAKE_DELAY    32'h0000_ffff
`define CMS_MIN_AWAKE_WIN     32'h0000_0001
`define CMS_MAX_AWAKE_WIN     32'h0036_ee80
`define CMS_MAX_ESCAPE_CHAR   32'h0000_00ff

// sleep mode codes and option bits
`define CMS_MODE_NONE         8'h00
`define CMS_MODE_PIN          8'h01
`define CMS_MODE_CYCLIC       8'h04
`define CMS_MODE_CYCLIC_PIN   8'h05
`define CMS_OPT_KEEP_ASSOC    6
`define CMS_OPT_NO_RESTART    8

// time bases
`define CMS_CLK_PERIOD_PS     5000
`define CMS_MS_PS             1000000000
`define CMS_MS_CYCLES         (`CMS_MS_PS / `CMS_CLK_PERIOD_PS)
`define CMS_IDLE_STEP_MS      100
`define CMS_SLEEP_STEP_MS     10
`define CMS_ESC_COUNT         3

`endif

// ---- verilog/cms_pkg.sv ----
/*
 * types shared by the command-mode and sleep controller.
 * assumes cms_params.svh is on the include path.
 */
`include "cms_params.svh"

package cms_pkg;

    typedef enum logic [1:0] {
        CMS_OP_READ  = 2'h0,
        CMS_OP_WRITE = 2'h1,
        CMS_OP_APPLY = 2'h2,
        CMS_OP_LEAVE = 2'h3
    } cms_op_e;

    typedef struct packed {
        cms_op_e     op;
        logic [3:0]  idx;
        logic [31:0] data;
    } cms_cmd_s;

    typedef struct packed {
        logic        ok;
        logic [31:0] data;
    } cms_rsp_s;

    typedef struct packed {
        logic [15:0] idle_timeout;
        logic [15:0] guard_time;
        logic [7:0]  escape_char;
        logic [7:0]  sleep_mode;
        logic [23:0] sleep_dur;
        logic [15:0] sleep_opt;
        logic [15:0] wake_delay;
        logic [23:0] awake_win;
        logic [23:0] join_wait;
    } cms_cfg_s;

endpackage : cms_pkg

// ---- verilog/cms_ms_tick.sv ----
/*
 * millisecond time base: one-cycle pulse every CYCLES clocks.
 * assumes a free-running ref_clk; simulation may shorten CYCLES.
 */
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_ms_tick
    import cms_pkg::*;
#(
    parameter int unsigned CYCLES = `CMS_MS_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    output logic      tick
);

    logic [31:0] count;

    always_ff @(posedge ref_clk) begin
        if (reset || count == CYCLES - 1) begin
            count <= 32'h0;
        end else begin
            count <= count + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        tick <= !reset && (count == CYCLES - 1);
    end

endmodule : cms_ms_tick

// ---- bench/cms_asserts.sv ----
/* port checker for cms_ctrl.
   assumes one clock and synchronous reset; bound to every cms_ctrl. */
`timescale 1ns/1ps
module cms_asserts
    import cms_pkg::*;
#(
    parameter int unsigned MS_CYCLES = 4
) (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic       data_valid,
    input wire logic [7:0] data_byte,
    input wire logic       cmd_valid,
    input wire cms_cmd_s   cmd,
    input wire logic       rsp_valid,
    input wire logic       command_mode,
    input wire logic       apply_strobe,
    input wire logic       serial_hold
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic taken = cmd_valid && command_mode;
    a_rsp_after_cmd: assert property (taken |=> rsp_valid) else $error("no response");
    a_no_stray_rsp: assert property (!taken |=> !rsp_valid) else $error("stray response");
    a_data_forward: assert property (rx_valid && !command_mode |=> data_valid
        && data_byte == $past(rx_byte)) else $error("character not forwarded");
    a_no_data_cmd: assert property (rx_valid && command_mode |=> !data_valid)
        else $error("data in command mode");
    a_leave_exits: assert property (taken && cmd.op == CMS_OP_LEAVE |=> !command_mode
        && apply_strobe) else $error("leave failed");
    a_apply_stays: assert property (taken && cmd.op == CMS_OP_APPLY |=> command_mode
        && apply_strobe) else $error("apply failed");
    a_exit_applies: assert property ($fell(command_mode) |-> apply_strobe)
        else $error("exit without apply");
    a_strobe_cause: assert property (apply_strobe |-> $past(taken) || $fell(command_mode))
        else $error("apply without cause");
    a_entry_quiet: assert property ($rose(command_mode) |-> !$past(rx_valid))
        else $error("entry during traffic");
    a_char_stops_hold: assert property (rx_valid |=> !serial_hold)
        else $error("hold not stopped");
endmodule : cms_asserts

bind cms_ctrl cms_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.ref_clk(ref_clk), .reset(reset),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .data_valid(data_valid), .data_byte(data_byte),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .command_mode(command_mode),
    .apply_strobe(apply_strobe), .serial_hold(serial_hold));

// ---- bench/cms_host.sv ----
/* host side of the serial port: characters and escape sequences.
   assumes the bench calls its tasks; drives on the falling edge. */
`timescale 1ns/1ps
module cms_host (
    input  wire logic ref_clk,
    output logic      rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        @(negedge ref_clk);
        rx_valid = 1'b1;
        rx_byte  = b;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_byte  = ~b; // idle line must not show a stale character
    endtask : send
    task automatic escape(input logic [7:0] esc, input int unsigned quiet);
        repeat (quiet) @(negedge ref_clk);
        repeat (3) send(esc);
        repeat (quiet) @(negedge ref_clk);
    endtask : escape
endmodule : cms_host

// ---- bench/tb_top.sv ----
/* self-checking bench for cms_ctrl with a 4-cycle ms tick.
   assumes cms_host as the serial host and the bound checker. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    import cms_pkg::*;
    localparam int unsigned MSC = 4;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic       cmd_valid = 1'b0;
    logic       sleep_pin = 1'b0;
    logic       asleep, keep_assoc, serial_hold;
    cms_cmd_s   cmd = '0;
    logic       rx_valid, data_valid, rsp_valid, command_mode, apply_strobe;
    logic [7:0] rx_byte, data_byte;
    cms_rsp_s   rsp;
    int         error_cnt = 0;
    int         compares = 0;
    logic [31:0] rst_v [3:11] = '{32'h64, 32'h3e8, 32'h2b, 32'h0, 32'hc8, 32'h100, 32'h0,
                                  32'h7d0, 32'h2710};
    always #2.5 ref_clk = ~ref_clk;
    cms_host host (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
    cms_ctrl #(.MS_CYCLES(MSC)) dut (.ref_clk(ref_clk), .reset(reset), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .data_valid(data_valid), .data_byte(data_byte),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
        .command_mode(command_mode), .apply_strobe(apply_strobe), .sleep_rq_pin(sleep_pin),
        .associated(1'b1), .work_pending(1'b0), .supply_mv_in(16'h0cf8),
        .link_margin_in(8'h2d), .asleep(asleep), .keep_association(keep_assoc),
        .serial_hold(serial_hold));
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic go(input cms_op_e op, input logic [3:0] idx, input logic [31:0] d);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd = '{op, idx, d};
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        `CHK("rsp_valid", 1'b1, rsp_valid)
    endtask : go
    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        host.send(8'h41);
        `CHK("forward", 9'h141, {data_valid, data_byte})
        repeat (1002 * MSC) @(negedge ref_clk);
        host.send(8'h2b);
        host.send(8'h41);
        repeat (1002 * MSC) @(negedge ref_clk);
        `CHK("aborted", 1'b0, command_mode)
        host.escape(8'h2b, 1002 * MSC);
        `CHK("entered", 1'b1, command_mode)
        for (int i = 3; i < 12; i++) begin
            go(CMS_OP_READ, 4'(i), 32'h0);
            `CHK("reset value", {1'b1, rst_v[i]}, rsp)
        end
        go(CMS_OP_READ, 4'h1, 32'h0);
        `CHK("supply", 33'h1_0000_0cf8, rsp)
        go(CMS_OP_READ, 4'h2, 32'h0);
        `CHK("margin", 33'h1_0000_002d, rsp)
        go(CMS_OP_READ, 4'h0, 32'h0);
        `CHK("code ok", 1'b1, rsp.ok)
        for (int m = 5; m >= 0; m--) begin
            go(CMS_OP_WRITE, 4'h6, 32'(m));
            `CHK("mode ok", m == 0 || m == 1 || m == 4 || m == 5, rsp.ok)
        end
        go(CMS_OP_WRITE, 4'h8, 32'h0);
        `CHK("option refused", 1'b0, rsp.ok)
        go(CMS_OP_WRITE, 4'h3, 32'h1);
        `CHK("timeout refused", 1'b0, rsp.ok)
        go(CMS_OP_WRITE, 4'h8, 32'h140);
        go(CMS_OP_WRITE, 4'h3, 32'h2);
        go(CMS_OP_WRITE, 4'h4, 32'h2);
        go(CMS_OP_WRITE, 4'h5, 32'h7e);
        go(CMS_OP_READ, 4'h3, 32'h0);
        `CHK("queued", 33'h1_0000_0064, rsp)
        go(CMS_OP_APPLY, 4'h0, 32'h0);
        go(CMS_OP_READ, 4'h8, 32'h0);
        `CHK("applied", 33'h1_0000_0140, rsp)
        go(CMS_OP_LEAVE, 4'h0, 32'h0);
        `CHK("left", 1'b0, command_mode)
        host.escape(8'h7e, 4 * MSC);
        `CHK("new escape", 1'b1, command_mode)
        repeat (600) @(negedge ref_clk);
        go(CMS_OP_READ, 4'h3, 32'h0);
        repeat (600) @(negedge ref_clk);
        `CHK("idle restarted", 1'b1, command_mode)
        repeat (300) @(negedge ref_clk);
        `CHK("idle exit", 1'b0, command_mode)
        host.escape(8'h7e, 4 * MSC);
        go(CMS_OP_WRITE, 4'h6, 32'h1);
        go(CMS_OP_WRITE, 4'h9, 32'h3);
        go(CMS_OP_LEAVE, 4'h0, 32'h0);
        // pin passes a three-stage synchroniser, then join and sleep
        sleep_pin = 1'b1;
        repeat (10) @(negedge ref_clk);
        `CHK("pin sleep", 2'b11, {asleep, keep_assoc})
        sleep_pin = 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK("host wait", 2'b01, {asleep, serial_hold})
        // a character ends the wait well before the 3 ms run out
        host.send(8'h41);
        `CHK("hold stopped", 1'b0, serial_hold)
        test_done();
    end
endmodule : tb_top
